// *** hw/drv1_timing_regs.sv ***
`timescale 1ns/100ps
module drv1_timing_regs
   import drv_timing_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic [7:0] cfg_addr,
   input  wire logic       cfg_wr,
   input  wire logic       cfg_rd,
   input  wire logic [7:0] cfg_wdata,
   output logic      [7:0] cfg_rdata_ff,
   input  wire logic       pri_drv1_timing_select,
   input  wire logic       sec_drv1_timing_select,
   input  wire logic [1:0] pri_drv0_sample_code,
   input  wire logic [1:0] pri_drv0_recover_code,
   input  wire logic [1:0] sec_drv0_sample_code,
   input  wire logic [1:0] sec_drv0_recover_code,
   input  wire logic       pri_drive1_access,
   input  wire logic       sec_drive1_access,
   output logic      [2:0] pri_sample_clks_ff,
   output logic      [2:0] pri_recover_clks_ff,
   output logic      [2:0] sec_sample_clks_ff,
   output logic      [2:0] sec_recover_clks_ff,
   output logic            pri_drv0_udma_en_ff,
   output logic            pri_drv1_udma_en_ff,
   output logic            sec_drv0_udma_en_ff,
   output logic            sec_drv1_udma_en_ff
);

////////////////////////////////////////////////////////////////////////////////
   logic [7:0] slave_drive_pio_timing_ff;
   logic [7:0] sync_dma_mode_enables_ff;

   wire hit_pio  = (cfg_addr == PIO_TIMING_OFFSET);
   wire hit_udma = (cfg_addr == UDMA_ENABLE_OFFSET);

   wire [7:0] nxt_pio_timing = (cfg_wr && hit_pio) ? cfg_wdata
                                : slave_drive_pio_timing_ff;
   // Upper nibble is not stored, so it cannot leak back
   wire [7:0] nxt_udma_en = (cfg_wr && hit_udma)
                            ? (cfg_wdata & UDMA_ENABLE_MASK)
                            : sync_dma_mode_enables_ff;
   wire [7:0] rd_mux = hit_pio  ? slave_drive_pio_timing_ff :
                       hit_udma ? sync_dma_mode_enables_ff : 8'h00;
   wire [7:0] nxt_rdata = cfg_rd ? rd_mux : 8'h00;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         slave_drive_pio_timing_ff <= PIO_TIMING_RESET;
         sync_dma_mode_enables_ff  <= UDMA_ENABLE_RESET;
         cfg_rdata_ff              <= 8'h00;
      end else begin
         slave_drive_pio_timing_ff <= nxt_pio_timing;
         sync_dma_mode_enables_ff  <= nxt_udma_en;
         cfg_rdata_ff              <= nxt_rdata;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // Field split of the drive 1 timing byte
   wire [1:0] sec_drv1_sample_point =
      slave_drive_pio_timing_ff[SEC_SAMPLE_LSB +: 2];
   wire [1:0] sec_drv1_recovery =
      slave_drive_pio_timing_ff[SEC_RECOVER_LSB +: 2];
   wire [1:0] pri_drv1_sample_point =
      slave_drive_pio_timing_ff[PRI_SAMPLE_LSB +: 2];
   wire [1:0] pri_drv1_recovery =
      slave_drive_pio_timing_ff[PRI_RECOVER_LSB +: 2];

   drv_timing_select u_pri (
      .core_clk           (core_clk),
      .sys_rst            (sys_rst),
      .drv1_timing_select (pri_drv1_timing_select),
      .drive1_access      (pri_drive1_access),
      .drv0_sample_code   (pri_drv0_sample_code),
      .drv0_recover_code  (pri_drv0_recover_code),
      .drv1_sample_code   (pri_drv1_sample_point),
      .drv1_recover_code  (pri_drv1_recovery),
      .sample_clks_ff     (pri_sample_clks_ff),
      .recover_clks_ff    (pri_recover_clks_ff)
   );

   drv_timing_select u_sec (
      .core_clk           (core_clk),
      .sys_rst            (sys_rst),
      .drv1_timing_select (sec_drv1_timing_select),
      .drive1_access      (sec_drive1_access),
      .drv0_sample_code   (sec_drv0_sample_code),
      .drv0_recover_code  (sec_drv0_recover_code),
      .drv1_sample_code   (sec_drv1_sample_point),
      .drv1_recover_code  (sec_drv1_recovery),
      .sample_clks_ff     (sec_sample_clks_ff),
      .recover_clks_ff    (sec_recover_clks_ff)
   );

////////////////////////////////////////////////////////////////////////////////
   // Enables leave with one flop of delay, same as the read path
   wire sec_drv1_udma_en = sync_dma_mode_enables_ff[SEC_DRV1_UDMA_BIT];
   wire sec_drv0_udma_en = sync_dma_mode_enables_ff[SEC_DRV0_UDMA_BIT];
   wire pri_drv1_udma_en = sync_dma_mode_enables_ff[PRI_DRV1_UDMA_BIT];
   wire pri_drv0_udma_en = sync_dma_mode_enables_ff[PRI_DRV0_UDMA_BIT];

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pri_drv0_udma_en_ff <= 1'b0;
         pri_drv1_udma_en_ff <= 1'b0;
         sec_drv0_udma_en_ff <= 1'b0;
         sec_drv1_udma_en_ff <= 1'b0;
      end else begin
         sec_drv1_udma_en_ff <= sec_drv1_udma_en;
         sec_drv0_udma_en_ff <= sec_drv0_udma_en;
         pri_drv1_udma_en_ff <= pri_drv1_udma_en;
         pri_drv0_udma_en_ff <= pri_drv0_udma_en;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // Checked one edge after reset, so no sampled history is needed
   reset_zero_a: assert property (@(posedge core_clk)
      sys_rst |=> slave_drive_pio_timing_ff == PIO_TIMING_RESET
                  && sync_dma_mode_enables_ff == UDMA_ENABLE_RESET)
      else $error("registers not zero after reset");

   reset_en_a: assert property (@(posedge core_clk)
      sys_rst |=> !pri_drv0_udma_en_ff && !pri_drv1_udma_en_ff
                  && !sec_drv0_udma_en_ff && !sec_drv1_udma_en_ff)
      else $error("udma enables not clear after reset");

   pio_write_a: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      cfg_wr && hit_pio |=> slave_drive_pio_timing_ff == $past(cfg_wdata))
      else $error("timing write not stored");

   pio_hold_a: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      !(cfg_wr && hit_pio)
      |=> slave_drive_pio_timing_ff == $past(slave_drive_pio_timing_ff))
      else $error("timing byte changed without a write");

   readback_a: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      cfg_rd && hit_pio && !cfg_wr
      |=> cfg_rdata_ff == slave_drive_pio_timing_ff)
      else $error("timing readback wrong");

   unmapped_rd_a: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      cfg_rd && !hit_pio && !hit_udma |=> cfg_rdata_ff == 8'h00)
      else $error("unmapped read not zero");

   idle_rd_a: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      !cfg_rd |=> cfg_rdata_ff == 8'h00)
      else $error("read data not zero while idle");

   udma_rsv_a: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      sync_dma_mode_enables_ff[7:4] == 4'h0)
      else $error("reserved enable bits set");

   udma_write_a: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      cfg_wr && hit_udma
      |=> sync_dma_mode_enables_ff[3:0] == $past(cfg_wdata[3:0]))
      else $error("enable write not stored");

   udma_readback_a: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      cfg_rd && hit_udma && !cfg_wr
      |=> cfg_rdata_ff[7:4] == 4'h0
          && cfg_rdata_ff[3:0] == sync_dma_mode_enables_ff[3:0])
      else $error("enable readback wrong");

   sec_en_a: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      cfg_wr && hit_udma ##2 !$past(sys_rst, 2)
      |-> sec_drv1_udma_en_ff == $past(cfg_wdata[3], 2)
          && sec_drv0_udma_en_ff == $past(cfg_wdata[2], 2))
      else $error("secondary udma enable wrong");

   pri_en_a: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      cfg_wr && hit_udma
      |-> ##2 pri_drv1_udma_en_ff == $past(cfg_wdata[1], 2)
          && pri_drv0_udma_en_ff == $past(cfg_wdata[0], 2))
      else $error("primary udma enable wrong");

   pri_shared_a: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      !pri_drv1_timing_select && pri_drv0_sample_code == 2'h0
      |=> pri_sample_clks_ff == 3'h5)
      else $error("primary drive 1 not sharing drive 0");

   sec_shared_a: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      !sec_drv1_timing_select && sec_drv0_recover_code == 2'h1
      |=> sec_recover_clks_ff == RECOVER_CLKS_01)
      else $error("secondary drive 1 not sharing drive 0");

   // Drive 0 accesses must never pick up the drive 1 fields
   pri_drv0_a: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      !pri_drive1_access && pri_drv0_recover_code == 2'h3
      |=> pri_recover_clks_ff == RECOVER_CLKS_11)
      else $error("primary drive 0 access used drive 1 timing");

   sec_drv0_a: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      !sec_drive1_access && sec_drv0_sample_code == 2'h2
      |=> sec_sample_clks_ff == SAMPLE_CLKS_10)
      else $error("secondary drive 0 access used drive 1 timing");

   sec_own_a: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      sec_drv1_timing_select && sec_drive1_access
      && sec_drv1_recovery == 2'h3
      |=> sec_recover_clks_ff == 3'h1)
      else $error("secondary drive 1 recovery wrong");

   sec_sample_a: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      sec_drv1_timing_select && sec_drive1_access
      && sec_drv1_sample_point == 2'h0
      |=> sec_sample_clks_ff == SAMPLE_CLKS_00)
      else $error("secondary drive 1 sample wrong");

   pri_own_a: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      pri_drv1_timing_select && pri_drive1_access
      && pri_drv1_sample_point == 2'h2
      |=> pri_sample_clks_ff == 3'h3)
      else $error("primary drive 1 sample wrong");

   pri_recover_a: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      pri_drv1_timing_select && pri_drive1_access
      && pri_drv1_recovery == 2'h0
      |=> pri_recover_clks_ff == RECOVER_CLKS_00)
      else $error("primary drive 1 recovery wrong");

   // Reserved code gives zero clocks; the user must treat it as invalid
   pri_rsv_a: assert property (@(posedge core_clk)
      disable iff (sys_rst)
      pri_drv1_timing_select && pri_drive1_access
      && pri_drv1_sample_point == 2'h3
      |=> pri_sample_clks_ff == SAMPLE_CLKS_RSV)
      else $error("primary reserved sample code not zero");

endmodule // drv1_timing_regs

// *** hw/drv_timing_pkg.sv ***
package drv_timing_pkg;

   // Configuration space byte offsets
   localparam logic [7:0] PIO_TIMING_OFFSET  = 8'h44;
   localparam logic [7:0] UDMA_ENABLE_OFFSET = 8'h48;

   // Reset values
   localparam logic [7:0] PIO_TIMING_RESET  = 8'h00;
   localparam logic [7:0] UDMA_ENABLE_RESET = 8'h00;

   // Field positions in slave_drive_pio_timing
   localparam int SEC_SAMPLE_LSB  = 6;
   localparam int SEC_RECOVER_LSB = 4;
   localparam int PRI_SAMPLE_LSB  = 2;
   localparam int PRI_RECOVER_LSB = 0;

   // Implemented bits of sync_dma_mode_enables
   localparam logic [7:0] UDMA_ENABLE_MASK = 8'h0F;
   localparam int SEC_DRV1_UDMA_BIT = 3;
   localparam int SEC_DRV0_UDMA_BIT = 2;
   localparam int PRI_DRV1_UDMA_BIT = 1;
   localparam int PRI_DRV0_UDMA_BIT = 0;

   // Clock counts for sample point codes 00/01/10
   localparam logic [2:0] SAMPLE_CLKS_00 = 3'h5;
   localparam logic [2:0] SAMPLE_CLKS_01 = 3'h4;
   localparam logic [2:0] SAMPLE_CLKS_10 = 3'h3;
   // Reserved code: reported as zero, caller treats zero as invalid
   localparam logic [2:0] SAMPLE_CLKS_RSV = 3'h0;

   // Clock counts for recovery codes
   localparam logic [2:0] RECOVER_CLKS_00 = 3'h4;
   localparam logic [2:0] RECOVER_CLKS_01 = 3'h3;
   localparam logic [2:0] RECOVER_CLKS_10 = 3'h2;
   localparam logic [2:0] RECOVER_CLKS_11 = 3'h1;

endpackage

// *** hw/drv_timing_select.sv ***
`timescale 1ns/100ps
module drv_timing_select
   import drv_timing_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       drv1_timing_select,
   input  wire logic       drive1_access,
   input  wire logic [1:0] drv0_sample_code,
   input  wire logic [1:0] drv0_recover_code,
   input  wire logic [1:0] drv1_sample_code,
   input  wire logic [1:0] drv1_recover_code,
   output logic      [2:0] sample_clks_ff,
   output logic      [2:0] recover_clks_ff
);

   function automatic logic [2:0] sample_clks(input logic [1:0] code);
      unique case (code)
         2'h0: sample_clks = SAMPLE_CLKS_00;
         2'h1: sample_clks = SAMPLE_CLKS_01;
         2'h2: sample_clks = SAMPLE_CLKS_10;
         2'h3: sample_clks = SAMPLE_CLKS_RSV;
      endcase
   endfunction

   function automatic logic [2:0] recover_clks(input logic [1:0] code);
      unique case (code)
         2'h0: recover_clks = RECOVER_CLKS_00;
         2'h1: recover_clks = RECOVER_CLKS_01;
         2'h2: recover_clks = RECOVER_CLKS_10;
         2'h3: recover_clks = RECOVER_CLKS_11;
      endcase
   endfunction

   // Own fields only for drive 1 with the select bit set
   wire       use_drv1 = drive1_access & drv1_timing_select;
   wire [1:0] sel_sample  = use_drv1 ? drv1_sample_code : drv0_sample_code;
   wire [1:0] sel_recover = use_drv1 ? drv1_recover_code
                                     : drv0_recover_code;
   wire [2:0] nxt_sample_clks  = sample_clks(sel_sample);
   wire [2:0] nxt_recover_clks = recover_clks(sel_recover);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sample_clks_ff  <= 3'h0;
         recover_clks_ff <= 3'h0;
      end else begin
         sample_clks_ff  <= nxt_sample_clks;
         recover_clks_ff <= nxt_recover_clks;
      end
   end

endmodule // drv_timing_select

// *** testbench/channel_model.sv ***
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// Stand-in for one channel's main timing register and its data-port
// target. Values change only on load so the bench knows them exactly.
////////////////////////////////////////////////////////////////////////
module channel_model (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       load,
   input  wire logic [5:0] load_val,
   output logic            drv1_timing_select,
   output logic            drive1_access,
   output logic      [1:0] drv0_sample_code,
   output logic      [1:0] drv0_recover_code
);
   logic [5:0] main_ff;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         main_ff <= 6'h00;
      end else if (load) begin
         main_ff <= load_val;
      end
   end
   assign {drv1_timing_select, drive1_access} = main_ff[5:4];
   assign {drv0_sample_code, drv0_recover_code} = main_ff[3:0];
endmodule // channel_model

// *** testbench/tb_ide_drive1_timing_udma_enable.sv ***
`timescale 1ns/100ps
module tb_ide_drive1_timing_udma_enable;
   import drv_timing_pkg::*;
   logic            core_clk = 1'b0;
   logic            sys_rst = 1'b1;
   logic      [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata_ff;
   logic            cfg_wr = 1'b0, cfg_rd = 1'b0, ld = 1'b0;
   wire       [1:0] sel, acc;
   wire  [1:0][1:0] s_code, r_code;
   wire  [1:0][2:0] smp, rcv;
   logic [1:0][5:0] mv = '0;
   wire       [3:0] udma;
   logic      [7:0] tim, ena;
   int              errors = 0, cmp_count = 0, cycles = 0;
   ////////////////////////////////////////////////////////////////////
   channel_model u_pri (.core_clk(core_clk), .sys_rst(sys_rst),
      .load(ld), .load_val(mv[0]), .drv1_timing_select(sel[0]),
      .drive1_access(acc[0]), .drv0_sample_code(s_code[0]),
      .drv0_recover_code(r_code[0]));
   channel_model u_sec (.core_clk(core_clk), .sys_rst(sys_rst),
      .load(ld), .load_val(mv[1]), .drv1_timing_select(sel[1]),
      .drive1_access(acc[1]), .drv0_sample_code(s_code[1]),
      .drv0_recover_code(r_code[1]));
   drv1_timing_regs u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_wdata(cfg_wdata), .cfg_rdata_ff(cfg_rdata_ff),
      .pri_drv1_timing_select(sel[0]), .sec_drv1_timing_select(sel[1]),
      .pri_drv0_sample_code(s_code[0]), .pri_drv0_recover_code(r_code[0]),
      .sec_drv0_sample_code(s_code[1]), .sec_drv0_recover_code(r_code[1]),
      .pri_drive1_access(acc[0]), .sec_drive1_access(acc[1]),
      .pri_sample_clks_ff(smp[0]), .pri_recover_clks_ff(rcv[0]),
      .sec_sample_clks_ff(smp[1]), .sec_recover_clks_ff(rcv[1]),
      .pri_drv0_udma_en_ff(udma[0]), .pri_drv1_udma_en_ff(udma[1]),
      .sec_drv0_udma_en_ff(udma[2]), .sec_drv1_udma_en_ff(udma[3]));
   ////////////////////////////////////////////////////////////////////
   always #5 core_clk = ~core_clk;
   // Whole run needs about 600 cycles; generous ceiling
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 6000) begin
         errors++;
         print_verdict();
      end
   end
   function automatic logic [2:0] smp_clks(logic [1:0] c);
      return (c == 2'h3) ? 3'h0 : 3'h5 - {1'b0, c};
   endfunction
   function automatic logic [2:0] rcv_clks(logic [1:0] c);
      return 3'h4 - {1'b0, c};
   endfunction
   task chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
      cmp_count++;
      if (got !== ex) begin
         $display("mismatch %s expected %h seen %h", nm, ex, got);
         errors++;
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      cfg_addr <= a;
      cfg_wdata <= d;
      cfg_wr <= 1'b1;
      @(posedge core_clk);
      cfg_wr <= 1'b0;
   endtask
   // Read data stands one cycle only, so it is taken right after the edge
   task rd(input logic [7:0] a, output logic [7:0] q);
      @(posedge core_clk);
      cfg_addr <= a;
      cfg_rd <= 1'b1;
      @(posedge core_clk);
      cfg_rd <= 1'b0;
      #1 q = cfg_rdata_ff;
   endtask
   task chk_out();
      logic [1:0] sc, rc;
      logic       use1;
      for (int ch = 0; ch < 2; ch++) begin
         use1 = mv[ch][5] & mv[ch][4];
         sc = use1 ? tim[ch*4+2 +: 2] : mv[ch][3:2];
         rc = use1 ? tim[ch*4 +: 2] : mv[ch][1:0];
         chk("sample_clks", 8'(smp_clks(sc)), 8'(smp[ch]));
         chk("recover_clks", 8'(rcv_clks(rc)), 8'(rcv[ch]));
      end
      chk("udma_en", ena & 8'h0F, {4'h0, udma});
   endtask
   task step(input logic [7:0] t, e, input logic [5:0] p, s);
      logic [7:0] q;
      wr(PIO_TIMING_OFFSET, t);
      wr(UDMA_ENABLE_OFFSET, e);
      tim = t;
      ena = e;
      @(posedge core_clk);
      mv <= {s, p};
      ld <= 1'b1;
      @(posedge core_clk);
      ld <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1 chk_out();
      rd(PIO_TIMING_OFFSET, q);
      chk("pio_timing", t, q);
      rd(UDMA_ENABLE_OFFSET, q);
      chk("udma_reg", e & 8'h0F, q);
   endtask
   task print_verdict();
      $display("comparisons %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] q;
      void'($urandom(9));
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      wr(8'h45, 8'hFF);
      rd(PIO_TIMING_OFFSET, q);
      chk("pio_reset", 8'h00, q);
      rd(UDMA_ENABLE_OFFSET, q);
      chk("udma_reset", 8'h00, q);
      rd(8'h45, q);
      chk("unmapped", 8'h00, q);
      // Every code on every field, drive 0 codes kept different
      for (int c = 0; c < 4; c++) begin
         step({4{2'(c)}}, 8'hF0, {2'h3, ~2'(c), ~2'(c)},
              {2'h3, ~2'(c), ~2'(c)});
      end
      for (int i = 0; i < 40; i++) begin
         step(8'($urandom), 8'($urandom), 6'($urandom), 6'($urandom));
      end
      print_verdict();
   end
endmodule // tb_ide_drive1_timing_udma_enable
